// *** hdl/pfs_top.sv ***
// Pin function selector: select registers and pad routing
`timescale 1ns/1ps
`default_nettype none
module pfs_top
    import pfs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Pads: input level, output level, output enable (low = driving)
    input  wire logic [7:0] pa_pad_i,
    output logic      [7:0] pa_pad_o,
    output logic      [7:0] pa_pad_oe_n_o,
    input  wire logic [7:0] pb_pad_i,
    output logic      [7:0] pb_pad_o,
    output logic      [7:0] pb_pad_oe_n_o,
    input  wire logic       pd_pad_i,
    output logic            pd_pad_o,
    output logic            pd_pad_oe_n_o,
    // GPIO port logic
    input  wire logic [7:0] pa_gpio_out_i,
    input  wire logic [7:0] pa_gpio_oe_i,
    output logic      [7:0] pa_gpio_in_o,
    input  wire logic [7:0] pb_gpio_out_i,
    input  wire logic [7:0] pb_gpio_oe_i,
    output logic      [7:0] pb_gpio_in_o,
    input  wire logic       pd_gpio_out_i,
    input  wire logic       pd_gpio_oe_i,
    output logic            pd_gpio_in_o,
    // Timer outputs
    input  wire logic       timer0_output_i,
    input  wire logic       timer0_inverted_output_i,
    input  wire logic       timer1_output_i,
    input  wire logic       timer1_inverted_output_i,
    input  wire logic       timer2_output_i,
    input  wire logic       timer2_inverted_output_i,
    input  wire logic       compact_timer_output_i,
    // Peripheral inputs fed from pads
    output logic            external_interrupt_0_o,
    output logic            external_interrupt_1_o,
    output logic            timer0_capture_input_o,
    output logic            timer1_capture_input_o,
    output logic            timer2_capture_input_o,
    output logic      [2:0] timer_clock_input_o,
    output logic            compact_timer_clock_input_o,
    // Overcurrent and capture sources
    input  wire logic       high_voltage_ground_pin_i,
    input  wire logic       overcurrent_comparator_output_i,
    input  wire logic       proximity_capture_i,
    input  wire logic       overcurrent_protect_enable_i,
    output logic            overcurrent_input_o,
    output logic            overcurrent_input_select_o,
    output logic            battery_driver_output_enable_o,
    // Analog switch enables, one per function
    output logic      [7:0] analog_channel_en_o,
    output logic            opamp0_output_en_o,
    output logic            opamp0_inverting_input_en_o,
    output logic            opamp0_noninverting_input_en_o,
    output logic            opamp1_output_en_o,
    output logic            opamp1_inverting_input_en_o,
    output logic            opamp1_noninverting_input_en_o,
    output logic            converter_reference_en_o,
    output logic            overcurrent_reference_en_o
);
    logic [7:0] port_a_low_select;
    logic [7:0] port_a_high_select;
    logic [7:0] port_b_low_select;
    logic [7:0] port_b_high_select;
    logic [7:0] port_d_select;
    logic [7:0] source_control;
    logic [7:0] capture_input_mux;
    logic [6:0] wr_sel;
    logic [7:0] next_rdata;

    assign wr_sel[0] = wr_i && (addr_i == OFS_PA_LOW);
    assign wr_sel[1] = wr_i && (addr_i == OFS_PA_HIGH);
    assign wr_sel[2] = wr_i && (addr_i == OFS_PB_LOW);
    assign wr_sel[3] = wr_i && (addr_i == OFS_PB_HIGH);
    assign wr_sel[4] = wr_i && (addr_i == OFS_PD);
    assign wr_sel[5] = wr_i && (addr_i == OFS_SRC_CTL);
    assign wr_sel[6] = wr_i && (addr_i == OFS_CAP_MUX);

    pfs_reg #(.MASK(MASK_FULL)) u_pa_low (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_sel[0]),
        .wdata_i (wdata_i),
        .q_o     (port_a_low_select)
    );
    pfs_reg #(.MASK(MASK_FULL)) u_pa_high (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_sel[1]),
        .wdata_i (wdata_i),
        .q_o     (port_a_high_select)
    );
    pfs_reg #(.MASK(MASK_PB_LOW)) u_pb_low (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_sel[2]),
        .wdata_i (wdata_i),
        .q_o     (port_b_low_select)
    );
    pfs_reg #(.MASK(MASK_FULL)) u_pb_high (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_sel[3]),
        .wdata_i (wdata_i),
        .q_o     (port_b_high_select)
    );
    pfs_reg #(.MASK(MASK_PD)) u_pd (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_sel[4]),
        .wdata_i (wdata_i),
        .q_o     (port_d_select)
    );
    pfs_reg #(.MASK(MASK_SRC_CTL)) u_src (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_sel[5]),
        .wdata_i (wdata_i),
        .q_o     (source_control)
    );
    pfs_reg #(.MASK(MASK_CAP_MUX)) u_cap (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_sel[6]),
        .wdata_i (wdata_i),
        .q_o     (capture_input_mux)
    );

    // Read path; unmapped offsets read zero
    always_comb begin
        unique case (addr_i)
            OFS_PA_LOW:  next_rdata = port_a_low_select;
            OFS_PA_HIGH: next_rdata = port_a_high_select;
            OFS_PB_LOW:  next_rdata = port_b_low_select;
            OFS_PB_HIGH: next_rdata = port_b_high_select;
            OFS_PD:      next_rdata = port_d_select;
            OFS_SRC_CTL: next_rdata = source_control;
            OFS_CAP_MUX: next_rdata = capture_input_mux;
            default:     next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end
    end

    // Per-pin codes
    wire [1:0] sa0 = port_a_low_select[1:0];
    wire [1:0] sa1 = port_a_low_select[3:2];
    wire [1:0] sa2 = port_a_low_select[5:4];
    wire [1:0] sa3 = port_a_low_select[7:6];
    wire [1:0] sa4 = port_a_high_select[1:0];
    wire [1:0] sa5 = port_a_high_select[3:2];
    wire [1:0] sa6 = port_a_high_select[5:4];
    wire [1:0] sa7 = port_a_high_select[7:6];
    wire [1:0] sb5 = port_b_high_select[3:2];
    wire [1:0] sb6 = port_b_high_select[5:4];
    wire [1:0] sb7 = port_b_high_select[7:6];
    wire [1:0] sd0 = port_d_select[1:0];

    // Per pin: GPIO ownership, timer drive, analog switches, input taps
    wire [7:0] pa_is_gpio;
    wire [7:0] pb_is_gpio;
    wire       pd_is_gpio;
    wire [7:0] pa_tmr_en;
    wire [7:0] pa_tmr_val;
    wire [7:0] pb_tmr_en;
    wire [7:0] pb_tmr_val;
    wire       ocp_pin;
    wire       cap_pin;

    // Pin A0: GPIO with interrupt 0, reference, timer 1, channel 0
    assign pa_is_gpio[0]              = (sa0 == CODE_00);
    assign pa_tmr_en[0]               = (sa0 == CODE_10);
    assign pa_tmr_val[0]              = timer1_output_i;
    assign analog_channel_en_o[0]     = (sa0 == CODE_11);
    assign overcurrent_reference_en_o = (sa0 == CODE_01);
    assign external_interrupt_0_o     = pa_pad_i[0] & pa_is_gpio[0];

    // Pin A1: op-amp 1 output, GPIO, channel 1
    assign pa_is_gpio[1]          = (sa1 == CODE_10);
    assign pa_tmr_en[1]           = 1'b0;
    assign pa_tmr_val[1]          = 1'b0;
    assign analog_channel_en_o[1] = (sa1 == CODE_11);
    assign opamp1_output_en_o     = ~sa1[1];

    // Pin A2: GPIO with interrupt 1 and capture 1, reference, timer 1 inverted
    assign pa_is_gpio[2]            = (sa2 == CODE_00);
    assign pa_tmr_en[2]             = (sa2 == CODE_10);
    assign pa_tmr_val[2]            = timer1_inverted_output_i;
    assign analog_channel_en_o[2]   = (sa2 == CODE_11);
    assign converter_reference_en_o = (sa2 == CODE_01);
    assign external_interrupt_1_o   = pa_pad_i[2] & pa_is_gpio[2];
    assign timer1_capture_input_o   = pa_pad_i[2] & pa_is_gpio[2];

    // Pin A3: op-amp 1 inverting input, GPIO, channel 3
    assign pa_is_gpio[3]               = (sa3 == CODE_10);
    assign pa_tmr_en[3]                = 1'b0;
    assign pa_tmr_val[3]               = 1'b0;
    assign analog_channel_en_o[3]      = (sa3 == CODE_11);
    assign opamp1_inverting_input_en_o = ~sa3[1];

    // Pin A4: op-amp 1 non-inverting input, GPIO, compact timer, channel 4
    assign pa_is_gpio[4]                  = (sa4 == CODE_01);
    assign pa_tmr_en[4]                   = (sa4 == CODE_10);
    assign pa_tmr_val[4]                  = compact_timer_output_i;
    assign analog_channel_en_o[4]         = (sa4 == CODE_11);
    assign opamp1_noninverting_input_en_o = (sa4 == CODE_00);

    // Pin A5: op-amp 0 non-inverting input, GPIO, channel 5
    assign pa_is_gpio[5]                  = (sa5 == CODE_10);
    assign pa_tmr_en[5]                   = 1'b0;
    assign pa_tmr_val[5]                  = 1'b0;
    assign analog_channel_en_o[5]         = (sa5 == CODE_11);
    assign opamp0_noninverting_input_en_o = ~sa5[1];

    // Pin A6: op-amp 0 inverting input, GPIO, channel 6
    assign pa_is_gpio[6]               = (sa6 == CODE_10);
    assign pa_tmr_en[6]                = 1'b0;
    assign pa_tmr_val[6]               = 1'b0;
    assign analog_channel_en_o[6]      = (sa6 == CODE_11);
    assign opamp0_inverting_input_en_o = ~sa6[1];

    // Pin A7: op-amp 0 output, GPIO, channel 7
    assign pa_is_gpio[7]          = (sa7 == CODE_10);
    assign pa_tmr_en[7]           = 1'b0;
    assign pa_tmr_val[7]          = 1'b0;
    assign analog_channel_en_o[7] = (sa7 == CODE_11);
    assign opamp0_output_en_o     = ~sa7[1];

    // Pin B0: GPIO, always tapped by timer 0 clock
    assign pb_is_gpio[0]          = 1'b1;
    assign pb_tmr_en[0]           = 1'b0;
    assign pb_tmr_val[0]          = 1'b0;
    assign timer_clock_input_o[0] = pb_pad_i[0];

    // Pin B1: GPIO, always tapped by timer 1 clock
    assign pb_is_gpio[1]          = 1'b1;
    assign pb_tmr_en[1]           = 1'b0;
    assign pb_tmr_val[1]          = 1'b0;
    assign timer_clock_input_o[1] = pb_pad_i[1];

    // Pin B2: GPIO, always tapped by timer 2 clock
    assign pb_is_gpio[2]          = 1'b1;
    assign pb_tmr_en[2]           = 1'b0;
    assign pb_tmr_val[2]          = 1'b0;
    assign timer_clock_input_o[2] = pb_pad_i[2];

    // Pin B3: plain GPIO
    assign pb_is_gpio[3] = 1'b1;
    assign pb_tmr_en[3]  = 1'b0;
    assign pb_tmr_val[3] = 1'b0;

    // Pin B4: GPIO, always tapped by compact timer clock
    assign pb_is_gpio[4]               = 1'b1;
    assign pb_tmr_en[4]                = 1'b0;
    assign pb_tmr_val[4]               = 1'b0;
    assign compact_timer_clock_input_o = pb_pad_i[4];

    // Pin B5: GPIO or timer 2 output
    assign pb_is_gpio[5] = ~sb5[1];
    assign pb_tmr_en[5]  = sb5[1];
    assign pb_tmr_val[5] = timer2_output_i;

    // Pin B6: GPIO or timer 0 output
    assign pb_is_gpio[6] = ~sb6[1];
    assign pb_tmr_en[6]  = sb6[1];
    assign pb_tmr_val[6] = timer0_output_i;

    // Pin B7: GPIO with capture 0, timer 0 inverted, overcurrent input
    assign pb_is_gpio[7]          = ~sb7[1];
    assign pb_tmr_en[7]           = (sb7 == CODE_10);
    assign pb_tmr_val[7]          = timer0_inverted_output_i;
    assign timer0_capture_input_o = pb_pad_i[7] & pb_is_gpio[7];
    assign ocp_pin                = pb_pad_i[7] & (sb7 == CODE_11);

    // Pin D0: GPIO with capture 2, or timer 2 inverted output
    assign pd_is_gpio = ~sd0[1];
    assign cap_pin    = pd_pad_i & pd_is_gpio;

    // Only the selected source may drive the pad
    wire [7:0] pa_drive    = (pa_is_gpio & pa_gpio_oe_i) | pa_tmr_en;
    wire [7:0] pb_drive    = (pb_is_gpio & pb_gpio_oe_i) | pb_tmr_en;
    wire       pd_drive    = (pd_is_gpio & pd_gpio_oe_i) | sd0[1];
    wire [7:0] next_pa_pad = (pa_tmr_en & pa_tmr_val) | (~pa_tmr_en & pa_gpio_out_i);
    wire [7:0] next_pb_pad = (pb_tmr_en & pb_tmr_val) | (~pb_tmr_en & pb_gpio_out_i);
    wire       next_pd_pad = sd0[1] ? timer2_inverted_output_i : pd_gpio_out_i;

    // Pads registered: one cycle late after a select change, but never glitching
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_pad_o      <= 8'h00;
            pa_pad_oe_n_o <= 8'hff;
        end else begin
            pa_pad_o      <= next_pa_pad;
            pa_pad_oe_n_o <= ~pa_drive;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pb_pad_o      <= 8'h00;
            pb_pad_oe_n_o <= 8'hff;
        end else begin
            pb_pad_o      <= next_pb_pad;
            pb_pad_oe_n_o <= ~pb_drive;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_pad_o      <= 1'b0;
            pd_pad_oe_n_o <= 1'b1;
        end else begin
            pd_pad_o      <= next_pd_pad;
            pd_pad_oe_n_o <= ~pd_drive;
        end
    end

    // Pad inputs reach GPIO readback only while GPIO owns the pin
    assign pa_gpio_in_o = pa_pad_i & pa_is_gpio;
    assign pb_gpio_in_o = pb_pad_i & pb_is_gpio;
    assign pd_gpio_in_o = pd_pad_i & pd_is_gpio;

    // Overcurrent source, gated by the group's protect enable
    wire ocp_src = source_control[BIT_OCP_SEL] ? ocp_pin : high_voltage_ground_pin_i;
    assign overcurrent_input_select_o     = source_control[BIT_OCP_SEL];
    assign battery_driver_output_enable_o = source_control[BIT_BAT_OE];
    assign overcurrent_input_o            = overcurrent_protect_enable_i & ocp_src;

    // Capture source for timer 2
    wire [1:0] cap_src = capture_input_mux[POS_CAP_SRC +: 2];
    assign timer2_capture_input_o = cap_src[1] ? proximity_capture_i :
        (cap_src[0] ? overcurrent_comparator_output_i : cap_pin);
endmodule
`default_nettype wire

// *** hdl/pfs_pkg.sv ***
// Constants for the pin function selector
package pfs_pkg;
    localparam logic [2:0] OFS_PA_LOW   = 3'h0;
    localparam logic [2:0] OFS_PA_HIGH  = 3'h1;
    localparam logic [2:0] OFS_PB_LOW   = 3'h2;
    localparam logic [2:0] OFS_PB_HIGH  = 3'h3;
    localparam logic [2:0] OFS_PD       = 3'h4;
    localparam logic [2:0] OFS_SRC_CTL  = 3'h5;
    localparam logic [2:0] OFS_CAP_MUX  = 3'h6;
    localparam logic [7:0] RST_SELECT   = 8'h00;
    localparam logic [7:0] MASK_FULL    = 8'hff;
    localparam logic [7:0] MASK_PB_LOW  = 8'h3f;
    localparam logic [7:0] MASK_PD      = 8'h03;
    localparam logic [7:0] MASK_SRC_CTL = 8'h03;
    localparam logic [7:0] MASK_CAP_MUX = 8'hc0;
    localparam int BIT_OCP_SEL  = 1;
    localparam int BIT_BAT_OE   = 0;
    localparam int POS_CAP_SRC  = 6;
    // Pad-level function codes
    localparam logic [1:0] CODE_00 = 2'h0;
    localparam logic [1:0] CODE_01 = 2'h1;
    localparam logic [1:0] CODE_10 = 2'h2;
    localparam logic [1:0] CODE_11 = 2'h3;
endpackage

// *** hdl/pfs_reg.sv ***
// One masked select register
`timescale 1ns/1ps
`default_nettype none
module pfs_reg
    import pfs_pkg::*;
#(
    parameter logic [7:0] MASK = 8'hff
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] q_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= RST_SELECT;
        end else if (we_i) begin
            q_o <= wdata_i & MASK;
        end
    end
endmodule
`default_nettype wire

// *** tb/pfs_props.sv ***
// Port assertions for the pin function selector
`timescale 1ns/1ps
`default_nettype none
module pfs_props
    import pfs_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] pb_pad_i,
    input wire logic [7:0] pb_pad_o,
    input wire logic [7:0] pb_pad_oe_n_o,
    input wire logic       timer0_output_i,
    input wire logic [2:0] timer_clock_input_o,
    input wire logic       compact_timer_clock_input_o,
    input wire logic       overcurrent_protect_enable_i,
    input wire logic       high_voltage_ground_pin_i,
    input wire logic       overcurrent_input_select_o,
    input wire logic       overcurrent_input_o,
    input wire logic [7:0] analog_channel_en_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_UNMAPPED_RD: assert property (rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_PB_LOW_RSV: assert property (
        rd_i && addr_i == OFS_PB_LOW |=> rdata_o[7:6] == 2'h0)
        else $error("port B low spare bits set");
    AST_CAP_RSV: assert property (
        rd_i && addr_i == OFS_CAP_MUX |=> rdata_o[5:0] == 6'h00)
        else $error("capture mux spare bits set");
    AST_READ_BACK: assert property (
        (wr_i && addr_i == OFS_PA_LOW) ##1 (rd_i && addr_i == OFS_PA_LOW)
        |=> rdata_o == $past(wdata_i, 2))
        else $error("port A low read back differs");
    AST_PA3_ANALOG: assert property (
        wr_i && addr_i == OFS_PA_LOW |=> analog_channel_en_o[3] == ($past(wdata_i) >= 8'hc0))
        else $error("channel 3 switch wrong");
    // Pad stage is registered, so the pin follows one cycle after the select
    AST_PB6_TIMER: assert property (
        (wr_i && addr_i == OFS_PB_HIGH && wdata_i[5]) ##1 !(wr_i && addr_i == OFS_PB_HIGH)
        |=> !pb_pad_oe_n_o[6] && pb_pad_o[6] == $past(timer0_output_i))
        else $error("pin B6 not driven by timer 0");
    AST_OCP_OFF: assert property (!overcurrent_protect_enable_i |-> !overcurrent_input_o)
        else $error("overcurrent input while disabled");
    AST_OCP_HIGH_VOLTAGE_GROUND_PIN: assert property (
        overcurrent_protect_enable_i && !overcurrent_input_select_o
        |-> overcurrent_input_o == high_voltage_ground_pin_i)
        else $error("overcurrent input not from ground pin");
    AST_TIMER_CLK: assert property (timer_clock_input_o == pb_pad_i[2:0])
        else $error("timer clock inputs not fed");
    AST_CT_CLK: assert property (compact_timer_clock_input_o == pb_pad_i[4])
        else $error("compact timer clock not fed");

    cover property (wr_i && addr_i == OFS_PB_HIGH && wdata_i[5]);
    cover property (rd_i && addr_i == 3'h7);
    cover property (overcurrent_protect_enable_i && overcurrent_input_o);
endmodule

bind pfs_top pfs_props chk_u (.*);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the pin function selector
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pfs_pkg::*;
;
    localparam logic [7:0] RD_MASK [8] = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'h03, 8'h03, 8'hc0, 8'h00};
    // Per code 0..3 with timers at code bit 0 and GPIO data its inverse
    localparam logic [7:0] PA_OE [4]  = '{8'hfa, 8'hef, 8'h00, 8'hff};
    localparam logic [7:0] PA_VAL [4] = '{8'h05, 8'h00, 8'hea, 8'h00};
    localparam logic [7:0] PB_VAL [4] = '{8'hff, 8'h00, 8'h1f, 8'h60};
    localparam logic [7:0] PA_GPIO [4] = '{8'h05, 8'h10, 8'hea, 8'h00};

    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       lvl = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] pa_pad_i = 8'hff;
    logic [7:0] pb_pad_i = 8'hff;
    logic       pd_pad_i = 1'b1;
    logic [7:0] pa_gpio_oe_i = 8'hff;
    logic [7:0] pb_gpio_oe_i = 8'hff;
    logic       pd_gpio_oe_i = 1'b1;
    logic       high_voltage_ground_pin_i = 1'b0;
    logic       overcurrent_comparator_output_i = 1'b0;
    logic       proximity_capture_i = 1'b0;
    logic       overcurrent_protect_enable_i = 1'b0;
    wire logic [7:0] pa_gpio_out_i = {8{~lvl}};
    wire logic [7:0] pb_gpio_out_i = {8{~lvl}};
    wire logic       pd_gpio_out_i = ~lvl;
    wire logic       timer0_output_i = lvl, timer0_inverted_output_i = lvl;
    wire logic       timer1_output_i = lvl, timer1_inverted_output_i = lvl;
    wire logic       timer2_output_i = lvl, timer2_inverted_output_i = lvl;
    wire logic       compact_timer_output_i = lvl;
    logic [7:0] rdata_o, pa_pad_o, pa_pad_oe_n_o, pb_pad_o, pb_pad_oe_n_o;
    logic [7:0] pa_gpio_in_o, pb_gpio_in_o, analog_channel_en_o;
    logic [2:0] timer_clock_input_o;
    logic       pd_pad_o, pd_pad_oe_n_o, pd_gpio_in_o, external_interrupt_0_o;
    logic       external_interrupt_1_o, timer0_capture_input_o, timer1_capture_input_o;
    logic       timer2_capture_input_o, compact_timer_clock_input_o, overcurrent_input_o;
    logic       overcurrent_input_select_o, battery_driver_output_enable_o;
    logic       opamp0_output_en_o, opamp0_inverting_input_en_o, opamp0_noninverting_input_en_o;
    logic       opamp1_output_en_o, opamp1_inverting_input_en_o, opamp1_noninverting_input_en_o;
    logic       converter_reference_en_o, overcurrent_reference_en_o;
    int         err_total = 0;
    int         total_checks = 0;
    int         cycles = 0;

    pfs_top dut_u (.*);

    always #2.5 clk_i = ~clk_i;

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // About 150 cycles of work; far above that means a hang
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            $display("ERROR %0t: timeout", $time);
            summarize();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand from the cycle after the strobe until the next read
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
    endtask

    task automatic t_regs();
        for (int a = 0; a < 8; a++) begin
            @(posedge clk_i);
            rd_chk(a[2:0], 8'h00);
        end
        for (int a = 0; a < 8; a++) begin
            wr_reg(a[2:0], 8'hff);
            rd_chk(a[2:0], RD_MASK[a]);
            wr_reg(a[2:0], 8'h00);
        end
    endtask

    task automatic t_pins();
        logic [1:0] c;
        logic       l;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            l = c[0];
            for (int a = 0; a < 5; a++)
                wr_reg(a[2:0], {4{c}});
            lvl <= l;
            @(posedge clk_i);
            @(negedge clk_i);
            chk(pa_pad_oe_n_o, PA_OE[i]);
            chk(pa_pad_o & ~PA_OE[i], PA_VAL[i]);
            chk(pb_pad_oe_n_o, {c == 2'h3, 7'h00});
            chk(pb_pad_o & ~pb_pad_oe_n_o, PB_VAL[i]);
            chk({6'h00, pd_pad_oe_n_o, pd_pad_o}, {7'h00, c[1] ? l : ~l});
            chk(analog_channel_en_o, {8{c == 2'h3}});
            chk({opamp1_inverting_input_en_o, opamp1_output_en_o, opamp0_output_en_o,
                 opamp0_inverting_input_en_o, opamp0_noninverting_input_en_o,
                 opamp1_noninverting_input_en_o, converter_reference_en_o,
                 overcurrent_reference_en_o},
                {{5{~c[1]}}, c == 2'h0, c == 2'h1, c == 2'h1});
            chk({3'h0, external_interrupt_0_o, external_interrupt_1_o, timer1_capture_input_o,
                 timer0_capture_input_o, timer2_capture_input_o},
                {3'h0, {3{c == 2'h0}}, {2{~c[1]}}});
            chk(pa_gpio_in_o, PA_GPIO[i]);
            chk(pb_gpio_in_o, c[1] ? 8'h1f : 8'hff);
            chk({7'h00, pd_gpio_in_o}, {7'h00, ~c[1]});
        end
        // GPIO that does not ask to drive leaves its pad free
        @(posedge clk_i);
        pb_gpio_oe_i <= 8'h00;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(pb_pad_oe_n_o, 8'h9f);
    endtask

    task automatic t_ocp();
        // Pin function first, protection enabled only afterwards
        wr_reg(OFS_PB_HIGH, 8'hc0);
        for (int s = 0; s < 2; s++) begin
            wr_reg(OFS_SRC_CTL, {6'h00, s[0], ~s[0]});
            @(negedge clk_i);
            chk({6'h00, overcurrent_input_select_o, battery_driver_output_enable_o},
                {6'h00, s[0], ~s[0]});
            for (int i = 0; i < 8; i++) begin
                @(posedge clk_i);
                overcurrent_protect_enable_i <= i[2];
                pb_pad_i                     <= {8{i[1]}};
                high_voltage_ground_pin_i    <= i[0];
                @(negedge clk_i);
                chk({7'h00, overcurrent_input_o}, {7'h00, i[2] & (s[0] ? i[1] : i[0])});
            end
        end
    endtask

    task automatic t_capture();
        wr_reg(OFS_PD, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr_reg(OFS_CAP_MUX, {c[1:0], 6'h00});
            for (int p = 0; p < 2; p++) begin
                @(posedge clk_i);
                pd_pad_i                        <= p[0];
                overcurrent_comparator_output_i <= ~p[0];
                proximity_capture_i             <= 1'b1;
                @(negedge clk_i);
                chk({7'h00, timer2_capture_input_o},
                    {7'h00, (c == 0) ? p[0] : (c == 1) ? ~p[0] : 1'b1});
            end
        end
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_pins();
        t_ocp();
        t_capture();
        summarize();
    end
endmodule
`default_nettype wire
